// file: design/tie_inv.sv
// Invalidation command engine over a 16-entry translation buffer.
// Assumes one command per cycle from the queue; fill port writes entries.
`timescale 1ns/1ps
`include "tie_cfg.svh"
module tie_inv (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire tie_pkg::tie_cmd_type    cmd,
	input  wire tie_pkg::tie_cfg_type    cfg,
	input  wire logic                    fill_en,
	input  wire logic [3:0]              fill_idx,
	input  wire tie_pkg::tie_entry_type  fill_entry,
	input  wire logic [3:0]              look_idx,
	output tie_pkg::tie_entry_type       look_entry,
	output tie_pkg::tie_rsp_type         rsp
);
	// =========================================================
	// State
	typedef struct packed {
		tie_pkg::tie_entry_type [`TIE_ENTRIES-1:0] ent;
		tie_pkg::tie_rsp_type                      rsp;
		tie_pkg::tie_entry_type                    look;
	} tie_state_type;

	tie_state_type state;
	tie_state_type next_state;

	// =========================================================
	// Helpers
	// Page address of a command, with low bits cleared, and reserved bits 51:48 cleared too when base_rev is set
	function automatic logic [63:12] page_of(input logic [63:0] a,
		input logic base_rev);
		logic [63:0] t;
		t = a;
		t[`TIE_PAGE_LSB-1:0] = '0;
		if (base_rev)
			t[`TIE_HI_MSB:`TIE_HI_LSB] = 4'h0;
		return t[63:12];
	endfunction

	// True when any address bit at or above the input size is set
	function automatic logic out_of_range(input logic [63:0] a,
		input logic [6:0] in_size);
		logic r;
		r = 1'b0;
		for (int i = 0; i < `TIE_VA_W; i++)
			if (i >= int'(in_size) && a[i])
				r = 1'b1;
		return r;
	endfunction

	// Leaf restriction: only last-level entries need go
	function automatic logic leaf_ok(input logic leaf,
		input tie_pkg::tie_entry_type e);
		return !leaf || e.last_lvl;
	endfunction

	logic              legal;
	logic              known;
	logic              sec;
	logic [63:12]      pg;
	logic              oor;
	logic [15:0]       hit;

	// =========================================================
	// Legality check per opcode and queue
	always_comb
	begin
		sec   = cmd.from_secure;
		known = 1'b1;
		legal = 1'b1;
		case (cmd.opcode)
			`TIE_OP_HOST_VAA, `TIE_OP_HOST_ASID:
				legal = cfg.host_supp;
			`TIE_OP_SEC_ALL, `TIE_OP_SEC_VA, `TIE_OP_SEC_VAA,
			`TIE_OP_SEC_ASID:
				legal = sec && cfg.sec_s2_supp;
			`TIE_OP_S2_ADDR, `TIE_OP_S12_VM:
				legal = cfg.s2_supp;
			`TIE_OP_SEC_S2_ADDR, `TIE_OP_SEC_S12_VM:
				legal = sec && cfg.sec_s2_supp;
			default:
				known = 1'b0;
		endcase
	end

	// =========================================================
	// Per-entry match
	always_comb
	begin
		pg  = page_of(cmd.addr, cfg.base_rev);
		oor = out_of_range(cmd.addr, cfg.in_addr_size);
		hit = '0;
		for (int i = 0; i < `TIE_ENTRIES; i++)
		begin
			tie_pkg::tie_entry_type e;
			e = state.ent[i];
			case (cmd.opcode)
				`TIE_OP_HOST_VAA:
					hit[i] = !e.is_ipa && e.addr == pg &&
						leaf_ok(cmd.leaf, e) &&
						(cfg.host_ext_nsec ?
						e.regime == tie_pkg::RG_NSEC_HOST_EXT :
						e.regime == tie_pkg::RG_NSEC_HOST);
				`TIE_OP_HOST_ASID:
					hit[i] = !e.global_e && e.asid == cmd.asid &&
						e.regime == tie_pkg::RG_NSEC_HOST_EXT;
				`TIE_OP_SEC_ALL:
					hit[i] = e.regime == tie_pkg::RG_SEC_HOST ||
						e.regime == tie_pkg::RG_SEC_HOST_EXT;
				`TIE_OP_SEC_VA:
					hit[i] = !e.is_ipa && e.addr == pg &&
						leaf_ok(cmd.leaf, e) &&
						(cfg.host_ext_s ?
						e.regime == tie_pkg::RG_SEC_HOST_EXT &&
						(e.global_e || e.asid == cmd.asid) :
						e.regime == tie_pkg::RG_SEC_HOST);
				`TIE_OP_SEC_VAA:
					hit[i] = !e.is_ipa && e.addr == pg &&
						leaf_ok(cmd.leaf, e) &&
						(cfg.host_ext_s ?
						e.regime == tie_pkg::RG_SEC_HOST_EXT :
						e.regime == tie_pkg::RG_SEC_HOST);
				`TIE_OP_SEC_ASID:
					hit[i] = !e.global_e && e.asid == cmd.asid &&
						e.regime == tie_pkg::RG_SEC_HOST_EXT;
				`TIE_OP_S2_ADDR:
					hit[i] = !oor && e.is_ipa && !e.nested &&
						e.regime == tie_pkg::RG_NSEC_GUEST &&
						e.vmid == cmd.vmid && e.addr == pg &&
						leaf_ok(cmd.leaf, e);
				`TIE_OP_S12_VM:
					hit[i] = e.regime == tie_pkg::RG_NSEC_GUEST &&
						e.vmid == cmd.vmid;
				`TIE_OP_SEC_S2_ADDR:
					hit[i] = !oor && e.is_ipa && !e.nested &&
						e.regime == tie_pkg::RG_SEC_GUEST &&
						e.ipa_space == cmd.ipa_space_select &&
						e.vmid == cmd.vmid && e.addr == pg &&
						leaf_ok(cmd.leaf, e);
				`TIE_OP_SEC_S12_VM:
					hit[i] = e.regime == tie_pkg::RG_SEC_GUEST &&
						e.vmid == cmd.vmid;
				default:
					hit[i] = 1'b0;
			endcase
			hit[i] = hit[i] && e.valid;
		end
	end

	// =========================================================
	// Next state: fills, kills and the response
	always_comb
	begin
		next_state = state;
		next_state.rsp = '0;
		if (fill_en)
			next_state.ent[fill_idx] = fill_entry;
		if (cmd.valid && known)
		begin
			next_state.rsp.done    = 1'b1;
			next_state.rsp.opcode  = cmd.opcode;
			next_state.rsp.illegal = !legal;
			if (legal)
			begin
				next_state.rsp.killed = hit;
				for (int i = 0; i < `TIE_ENTRIES; i++)
					if (hit[i])
						next_state.ent[i].valid = 1'b0;
			end
		end
		next_state.look = next_state.ent[look_idx];
	end

	// Kill beats a same-cycle fill of a matching slot
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign rsp        = state.rsp;
	assign look_entry = state.look;

	// =========================================================
	// Checks
	a_illegal_no_kill: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rsp.illegal |-> rsp.killed == 16'h0000)
		else $error("illegal command killed entries");
	a_host_needs_supp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && !cfg.host_supp &&
		cmd.opcode == `TIE_OP_HOST_VAA |=> rsp.illegal)
		else $error("host command without support not illegal");
	a_sec_from_ns: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && !cmd.from_secure &&
		cmd.opcode == `TIE_OP_SEC_VA |=> rsp.done && rsp.illegal)
		else $error("secure command from nonsecure queue accepted");
	a_s2_needs_supp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && !cfg.s2_supp &&
		cmd.opcode == `TIE_OP_S12_VM |=> rsp.illegal)
		else $error("stage-two command without support not illegal");
	a_sec_s2_nsec_q: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && !cmd.from_secure &&
		cmd.opcode == `TIE_OP_SEC_S12_VM |=> rsp.illegal)
		else $error("secure stage-two from nonsecure queue accepted");
	a_legal_nsec_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && cfg.s2_supp &&
		cmd.opcode == `TIE_OP_S2_ADDR |=> rsp.done && !rsp.illegal)
		else $error("stage-two command refused");
	a_vm_kill_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && cfg.s2_supp && !fill_en &&
		cmd.opcode == `TIE_OP_S12_VM && hit[look_idx]
		|=> !look_entry.valid)
		else $error("machine command left matching entry");
	a_leaf_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd.valid && cmd.leaf && cmd.opcode == `TIE_OP_HOST_VAA
		|-> (hit & ~{state.ent[15].last_lvl, state.ent[14].last_lvl,
		state.ent[13].last_lvl, state.ent[12].last_lvl,
		state.ent[11].last_lvl, state.ent[10].last_lvl,
		state.ent[9].last_lvl, state.ent[8].last_lvl,
		state.ent[7].last_lvl, state.ent[6].last_lvl,
		state.ent[5].last_lvl, state.ent[4].last_lvl,
		state.ent[3].last_lvl, state.ent[2].last_lvl,
		state.ent[1].last_lvl, state.ent[0].last_lvl}) == 16'h0000)
		else $error("leaf command hit non-leaf entry");
endmodule // tie_inv

// file: design/tie_cfg.svh
// Constants for the stage-two and host invalidation command block.
// Assumes inclusion by design and bench files; holds definitions.
`ifndef TIE_CFG_SVH
`define TIE_CFG_SVH
// Opcodes of the handled commands (8-bit opcode field)
`define TIE_OP_HOST_VAA      8'h2b
`define TIE_OP_HOST_ASID     8'h2c
`define TIE_OP_SEC_ALL       8'h50
`define TIE_OP_SEC_VA        8'h51
`define TIE_OP_SEC_VAA       8'h52
`define TIE_OP_SEC_ASID      8'h53
`define TIE_OP_S2_ADDR       8'h2a
`define TIE_OP_S12_VM        8'h28
`define TIE_OP_SEC_S2_ADDR   8'h5a
`define TIE_OP_SEC_S12_VM    8'h58
// Buffer geometry and field positions
`define TIE_ENTRIES          16
`define TIE_PAGE_LSB         12
`define TIE_HI_LSB           48
`define TIE_HI_MSB           51
`define TIE_ADDR_W           52
`define TIE_VA_W             64
`endif

// file: design/tie_pkg.sv
// Types shared by the invalidation block.
// Assumes tie_cfg.svh supplies numeric constants.
`include "tie_cfg.svh"
package tie_pkg;
	// Translation regime stored with each entry
	typedef enum logic [6:0] {
		RG_NSEC_GUEST    = 7'b000_0001,
		RG_NSEC_HOST     = 7'b000_0010,
		RG_NSEC_HOST_EXT = 7'b000_0100,
		RG_SEC_GUEST     = 7'b000_1000,
		RG_SEC_HOST      = 7'b001_0000,
		RG_SEC_HOST_EXT  = 7'b010_0000,
		RG_NONE          = 7'b100_0000
	} tie_regime_type;
	// One cached translation
	typedef struct packed {
		logic              valid;
		tie_regime_type    regime;
		logic              is_ipa;    // Stage-two-only entry
		logic              nested;    // Combined stage entry
		logic              global_e;
		logic              last_lvl;
		logic              ipa_space;
		logic [15:0]       vmid;
		logic [15:0]       asid;
		logic [63:12]      addr;
	} tie_entry_type;
	// One command from a queue
	typedef struct packed {
		logic              valid;
		logic              from_secure;
		logic [7:0]        opcode;
		logic [15:0]       vmid;
		logic [15:0]       asid;
		logic [63:0]       addr;
		logic              leaf;
		logic              ipa_space_select;
	} tie_cmd_type;
	// Feature support and controls
	typedef struct packed {
		logic              host_supp;
		logic              s2_supp;
		logic              sec_s2_supp;
		logic              base_rev;
		logic [6:0]        in_addr_size;
		logic              host_ext_nsec;
		logic              host_ext_s;
	} tie_cfg_type;
	// Outcome of one command
	typedef struct packed {
		logic              done;
		logic              illegal;
		logic [7:0]        opcode;
		logic [15:0]       killed;
	} tie_rsp_type;
endpackage

// file: dv/tb_tie_inv.sv
// Self-checking bench for the host and stage-two invalidation engine.
// Assumes tie_pkg and tie_cfg.svh are compiled first; no partner model.
`timescale 1ns/1ps
`include "tie_cfg.svh"
module tb_tie_inv;
	logic                   ref_clk;
	logic                   rst_n;
	tie_pkg::tie_cmd_type   cmd;
	tie_pkg::tie_cfg_type   cfg;
	logic                   fill_en;
	logic [3:0]             fill_idx;
	tie_pkg::tie_entry_type fill_entry;
	logic [3:0]             look_idx;
	tie_pkg::tie_entry_type look_entry;
	tie_pkg::tie_rsp_type   rsp;
	tie_pkg::tie_rsp_type   r;
	tie_pkg::tie_cfg_type   k;
	logic                   rev;
	logic                   sel;
	int                     miscompares;
	int                     comparisons;
	int                     cycles;
	logic [7:0]             ops [10];

	tie_inv i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .cfg(cfg),
		.fill_en(fill_en), .fill_idx(fill_idx), .fill_entry(fill_entry),
		.look_idx(look_idx), .look_entry(look_entry), .rsp(rsp));

	// ===========================================================
	// Clock and hang guard
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	// ===========================================================
	// Helpers
	task automatic check(string what, logic [15:0] got, logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Legality from queue and feature bits only
	function automatic logic legal(logic [7:0] op, logic sec,
		tie_pkg::tie_cfg_type c);
		case (op)
			`TIE_OP_HOST_VAA, `TIE_OP_HOST_ASID: legal = c.host_supp;
			`TIE_OP_S2_ADDR, `TIE_OP_S12_VM: legal = c.s2_supp;
			default: legal = sec & c.sec_s2_supp;
		endcase
	endfunction
	// Fixed population: host, stage-two and secure entries
	function automatic tie_pkg::tie_entry_type mk(int i);
		mk = '0;
		mk.valid = 1'b1;
		mk.last_lvl = 1'b1;
		// No combined entries, so no first-stage kill must follow
		mk.nested = 1'b0;
		mk.asid = 16'h0003;
		mk.vmid = (i == 4) ? 16'h0008 : 16'h0007;
		mk.addr = (i == 2) ? 52'h6 : (i == 5) ? 52'h9 : 52'h5;
		mk.is_ipa = (i == 3 || i == 4 || i == 7);
		case (i)
			0, 2: mk.regime = tie_pkg::RG_NSEC_HOST_EXT;
			1: mk.regime = tie_pkg::RG_NSEC_HOST;
			6: mk.regime = tie_pkg::RG_SEC_HOST_EXT;
			7: mk.regime = tie_pkg::RG_SEC_GUEST;
			default: mk.regime = tie_pkg::RG_NSEC_GUEST;
		endcase
	endfunction
	// Command held one cycle; answer awaited under a bound
	task automatic send(tie_pkg::tie_cmd_type c, tie_pkg::tie_cfg_type q);
		int n;
		@(posedge ref_clk);
		cmd <= c;
		cfg <= q;
		@(posedge ref_clk);
		cmd.valid <= 1'b0;
		n = 0;
		r = '0;
		while (n < 4 && r.done !== 1'b1)
		begin
			#1 r = rsp;
			if (r.done !== 1'b1)
				@(posedge ref_clk);
			n++;
		end
	endtask
	// Refill, issue, compare the kill map on the bits that matter
	task automatic run(logic [7:0] op, logic sec, logic hext, logic [51:0] pg,
		logic [15:0] vm, logic [15:0] exp, logic [15:0] care);
		tie_pkg::tie_cmd_type c;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			fill_en <= 1'b1;
			fill_idx <= 4'(i);
			fill_entry <= mk(i);
			@(posedge ref_clk);
			fill_en <= 1'b0;
		end
		c = '0;
		c = '{valid: 1'b1, from_secure: sec, opcode: op, vmid: vm,
			asid: 16'h0003, addr: {pg, 12'hfff}, leaf: 1'b1,
			ipa_space_select: sel};
		// Host extension always known when an address command goes out
		k = '{1'b1, 1'b1, 1'b1, rev, 7'h30, hext, hext};
		send(c, k);
		check("done", 16'(r.done), 16'h0001);
		check("opcode", 16'(r.opcode), 16'(op));
		check("illegal", 16'(r.illegal), 16'h0000);
		check("killed", r.killed & care, exp);
	endtask

	// ===========================================================
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		cmd = '0;
		cfg = '0;
		fill_en = 1'b0;
		fill_idx = 4'h0;
		fill_entry = '0;
		look_idx = 4'h0;
		rev = 1'b0;
		sel = 1'b0;
		ops = '{`TIE_OP_HOST_VAA, `TIE_OP_HOST_ASID, `TIE_OP_SEC_ALL,
			`TIE_OP_SEC_VA, `TIE_OP_SEC_VAA, `TIE_OP_SEC_ASID,
			`TIE_OP_S2_ADDR, `TIE_OP_S12_VM, `TIE_OP_SEC_S2_ADDR,
			`TIE_OP_SEC_S12_VM};
		void'($urandom(32'h07e8_6318));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		run(`TIE_OP_HOST_VAA, 0, 1, 52'h5, 16'h0, 16'h0001, 16'h0045);
		repeat (2) @(posedge ref_clk);
		#1 check("look valid", 16'(look_entry.valid), 16'h0000);
		run(`TIE_OP_HOST_VAA, 0, 0, 52'h5, 16'h0, 16'h0002, 16'h0042);
		run(`TIE_OP_HOST_ASID, 1, 1, 52'h0, 16'h0, 16'h0005, 16'h0045);
		run(`TIE_OP_S2_ADDR, 1, 0, 52'h5, 16'h7, 16'h0008, 16'h0098);
		run(`TIE_OP_S12_VM, 0, 0, 52'h0, 16'h7, 16'h0028, 16'h00b8);
		run(`TIE_OP_SEC_S12_VM, 1, 0, 52'h0, 16'h7, 16'h0080, 16'h00a8);
		run(`TIE_OP_SEC_S2_ADDR, 1, 0, 52'h5, 16'h7, 16'h0080, 16'h0088);
		run(`TIE_OP_SEC_VAA, 1, 1, 52'h5, 16'h0, 16'h0040, 16'h0041);
		// Base revision: bit 48 of the address is dropped before matching
		rev = 1'b1;
		run(`TIE_OP_HOST_VAA, 0, 1, 52'h10_0000_0005,
			16'h0, 16'h0001, 16'h0045);
		// Same page, but raw bit 48 lies above the input size
		run(`TIE_OP_S2_ADDR, 1, 0, 52'h10_0000_0005,
			16'h7, 16'h0000, 16'h0098);
		rev = 1'b0;
		// Selector picks the other address space: slot 7 survives
		sel = 1'b1;
		run(`TIE_OP_SEC_S2_ADDR, 1, 0, 52'h5, 16'h7, 16'h0000, 16'h0080);
		sel = 1'b0;
		// Random queue and feature mix; legality only
		for (int n = 0; n < 300; n++)
		begin
			tie_pkg::tie_cmd_type c;
			logic ill;
			c = '0;
			c.valid = 1'b1;
			c.opcode = ops[$urandom_range(9)];
			c.from_secure = 1'($urandom);
			c.vmid = 16'($urandom_range(8));
			c.addr = {44'h0, 8'($urandom), 12'h000};
			c.leaf = 1'($urandom);
			k = 13'($urandom);
			k.in_addr_size = 7'h30;
			look_idx <= 4'($urandom);
			send(c, k);
			ill = !legal(c.opcode, c.from_secure, k);
			check("done", 16'(r.done), 16'h0001);
			check("illegal", 16'(r.illegal), 16'(ill));
			if (r.illegal === 1'b1)
				check("killed", r.killed, 16'h0000);
		end
		// Unknown opcode draws no answer
		send('{1'b1, 1'b0, 8'h00, 16'h0, 16'h0, 64'h0, 1'b0, 1'b0}, k);
		check("done", 16'(r.done), 16'h0000);
		summarize();
	end
endmodule // tb_tie_inv
